// ===== rtl/tdfb_flag_bank.v
// latched diagnostic flag bytes and module monitor bytes of the transceiver lower page
`timescale 1ns/1ns
`include "tdfb_map.vh"

module tdfb_flag_bank #(
    parameter MON_W = 16,
    parameter CH_N  = 4
) (
    input  wire                         clock,
    input  wire                         resetn,
    input  wire                         module_reset_n,
    input  wire                         rd_strobe,
    input  wire [`TDFB_ADDR_W-1:0]      rd_addr,
    output reg  [7:0]                   rd_data,
    output reg                          rd_valid,
    input  wire [CH_N-1:0]              rx_los_in,
    input  wire [CH_N-1:0]              tx_fault_in,
    input  wire [MON_W-1:0]             temperature_in,
    input  wire [MON_W-1:0]             supply_voltage_in,
    input  wire [CH_N*MON_W-1:0]        rx_power_in,
    input  wire [CH_N*MON_W-1:0]        tx_bias_in,
    input  wire [CH_N*MON_W-1:0]        tx_power_in,
    input  wire [4*MON_W-1:0]           temp_thresh,
    input  wire [4*MON_W-1:0]           vcc_thresh,
    input  wire [4*MON_W-1:0]           rx_power_thresh,
    input  wire [4*MON_W-1:0]           tx_bias_thresh,
    input  wire [4*MON_W-1:0]           tx_power_thresh
);

    ////////////////////////////////////////////////////////////////////////////
    // threshold compare, shared by every monitored quantity
    ////////////////////////////////////////////////////////////////////////////

    // returns {high alarm, low alarm, high warning, low warning}
    // temperature is two's complement, all other quantities unsigned
    function [3:0] tdfb_cmp;
        input [MON_W-1:0]   val;
        input [4*MON_W-1:0] thr;
        input               is_signed;
        reg   [MON_W-1:0]   v;
        reg   [MON_W-1:0]   ha;
        reg   [MON_W-1:0]   la;
        reg   [MON_W-1:0]   hw;
        reg   [MON_W-1:0]   lw;
        reg   [MON_W-1:0]   flip;
        begin
            // flipping the sign bit turns a signed compare into an unsigned one
            flip = {is_signed, {(MON_W-1){1'b0}}};
            v  = val ^ flip;
            ha = thr[`TDFB_THR_HA_LSB +: MON_W] ^ flip;
            la = thr[`TDFB_THR_LA_LSB +: MON_W] ^ flip;
            hw = thr[`TDFB_THR_HW_LSB +: MON_W] ^ flip;
            lw = thr[`TDFB_THR_LW_LSB +: MON_W] ^ flip;
            tdfb_cmp[`TDFB_NIB_HA] = (v > ha);
            tdfb_cmp[`TDFB_NIB_LA] = (v < la);
            tdfb_cmp[`TDFB_NIB_HW] = (v > hw);
            tdfb_cmp[`TDFB_NIB_LW] = (v < lw);
        end
    endfunction

    // one nibble per channel, channel 1 in the top nibble of the pair
    // all channels of a quantity share one threshold set
    function [4*CH_N-1:0] tdfb_chan_cmp;
        input [CH_N*MON_W-1:0] vals;
        input [4*MON_W-1:0]    thr;
        integer                i;
        begin
            tdfb_chan_cmp = {(4*CH_N){1'b0}};
            for (i = 0; i < CH_N; i = i + 1) begin
                tdfb_chan_cmp[4*(CH_N-1-i) +: 4] =
                    tdfb_cmp(vals[i*MON_W +: MON_W], thr, 1'b0);
            end
        end
    endfunction

    // one read strobe aimed at one byte address
    // shared by the read-clear strobes and the monitor pair capture
    function tdfb_hit;
        input                    strobe;
        input [`TDFB_ADDR_W-1:0] addr;
        input [`TDFB_ADDR_W-1:0] target;
        begin
            tdfb_hit = strobe && (addr == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // module reset pin: three stages, level taken once stages two and three agree
    ////////////////////////////////////////////////////////////////////////////

    reg mrst_s1_reg;
    reg mrst_s2_reg;
    reg mrst_s3_reg;
    reg mrst_n_reg;

    // a single-cycle glitch on the pin never clears the flags
    // stage one feeds only stage two, so a metastable level never fans out
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mrst_s1_reg <= 1'b1;
            mrst_s2_reg <= 1'b1;
            mrst_s3_reg <= 1'b1;
            mrst_n_reg  <= 1'b1;
        end else begin
            mrst_s1_reg <= module_reset_n;
            mrst_s2_reg <= mrst_s1_reg;
            mrst_s3_reg <= mrst_s2_reg;
            if (mrst_s2_reg == mrst_s3_reg) begin
                mrst_n_reg <= mrst_s3_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag conditions
    ////////////////////////////////////////////////////////////////////////////

    wire [3:0]        temp_set;
    wire [3:0]        vcc_set;
    wire [4*CH_N-1:0] rxp_set;
    wire [4*CH_N-1:0] bias_set;
    wire [4*CH_N-1:0] txp_set;

    // threshold crossings, evaluated every cycle
    // strict compares: a value equal to a threshold raises nothing
    assign temp_set = tdfb_cmp(temperature_in, temp_thresh, 1'b1);
    assign vcc_set  = tdfb_cmp(supply_voltage_in, vcc_thresh, 1'b0);
    assign rxp_set  = tdfb_chan_cmp(rx_power_in, rx_power_thresh);
    assign bias_set = tdfb_chan_cmp(tx_bias_in, tx_bias_thresh);
    assign txp_set  = tdfb_chan_cmp(tx_power_in, tx_power_thresh);

    ////////////////////////////////////////////////////////////////////////////
    // read-clear strobes, one per flag byte
    ////////////////////////////////////////////////////////////////////////////

    wire clr_los;
    wire clr_fault;
    wire clr_temp;
    wire clr_vcc;
    wire clr_rxp12;
    wire clr_rxp34;
    wire clr_bias12;
    wire clr_bias34;
    wire clr_txp12;
    wire clr_txp34;

    // a read of a byte clears exactly the flags that byte returned
    // same address compare as the read mux, so no byte is cleared unseen
    assign clr_los    = tdfb_hit(rd_strobe, rd_addr, `TDFB_CHANNEL_LOS);
    assign clr_fault  = tdfb_hit(rd_strobe, rd_addr, `TDFB_TX_FAULT);
    assign clr_temp   = tdfb_hit(rd_strobe, rd_addr, `TDFB_TEMP_FLAGS);
    assign clr_vcc    = tdfb_hit(rd_strobe, rd_addr, `TDFB_VCC_FLAGS);
    assign clr_rxp12  = tdfb_hit(rd_strobe, rd_addr, `TDFB_RXP_CH12);
    assign clr_rxp34  = tdfb_hit(rd_strobe, rd_addr, `TDFB_RXP_CH34);
    assign clr_bias12 = tdfb_hit(rd_strobe, rd_addr, `TDFB_BIAS_CH12);
    assign clr_bias34 = tdfb_hit(rd_strobe, rd_addr, `TDFB_BIAS_CH34);
    assign clr_txp12  = tdfb_hit(rd_strobe, rd_addr, `TDFB_TXP_CH12);
    assign clr_txp34  = tdfb_hit(rd_strobe, rd_addr, `TDFB_TXP_CH34);

    ////////////////////////////////////////////////////////////////////////////
    // latched flags: set wins over a read-clear in the same cycle; the module reset pin wins over both
    ////////////////////////////////////////////////////////////////////////////

    reg  [CH_N-1:0]   los_reg;
    reg  [CH_N-1:0]   fault_reg;
    reg  [3:0]        temp_flag_reg;
    reg  [3:0]        vcc_flag_reg;
    reg  [4*CH_N-1:0] rxp_flag_reg;
    reg  [4*CH_N-1:0] bias_flag_reg;
    reg  [4*CH_N-1:0] txp_flag_reg;

    wire [CH_N-1:0]   los_next;
    wire [CH_N-1:0]   fault_next;
    wire [3:0]        temp_flag_next;
    wire [3:0]        vcc_flag_next;
    wire [4*CH_N-1:0] rxp_flag_next;
    wire [4*CH_N-1:0] bias_flag_next;
    wire [4*CH_N-1:0] txp_flag_next;

    // pair halves: upper byte holds channels 1 and 2, lower byte 3 and 4
    assign los_next       = (los_reg & {CH_N{~clr_los}}) | rx_los_in;
    assign fault_next     = (fault_reg & {CH_N{~clr_fault}}) | tx_fault_in;
    assign temp_flag_next = (temp_flag_reg & {4{~clr_temp}}) | temp_set;
    assign vcc_flag_next  = (vcc_flag_reg & {4{~clr_vcc}}) | vcc_set;
    assign rxp_flag_next  = (rxp_flag_reg & {{8{~clr_rxp12}}, {8{~clr_rxp34}}})
                            | rxp_set;
    assign bias_flag_next = (bias_flag_reg & {{8{~clr_bias12}}, {8{~clr_bias34}}})
                            | bias_set;
    assign txp_flag_next  = (txp_flag_reg & {{8{~clr_txp12}}, {8{~clr_txp34}}})
                            | txp_set;

    // module reset pin holds every flag clear once it has been asserted for two cycles or more
    // the pin acts as a level through mrst_n_reg, four clocks late: flags stay clear until four clocks after it rises
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            los_reg       <= {CH_N{1'b0}};
            fault_reg     <= {CH_N{1'b0}};
            temp_flag_reg <= 4'h0;
            vcc_flag_reg  <= 4'h0;
            rxp_flag_reg  <= {(4*CH_N){1'b0}};
            bias_flag_reg <= {(4*CH_N){1'b0}};
            txp_flag_reg  <= {(4*CH_N){1'b0}};
        end else if (!mrst_n_reg) begin
            los_reg       <= {CH_N{1'b0}};
            fault_reg     <= {CH_N{1'b0}};
            temp_flag_reg <= 4'h0;
            vcc_flag_reg  <= 4'h0;
            rxp_flag_reg  <= {(4*CH_N){1'b0}};
            bias_flag_reg <= {(4*CH_N){1'b0}};
            txp_flag_reg  <= {(4*CH_N){1'b0}};
        end else begin
            los_reg       <= los_next;
            fault_reg     <= fault_next;
            temp_flag_reg <= temp_flag_next;
            vcc_flag_reg  <= vcc_flag_next;
            rxp_flag_reg  <= rxp_flag_next;
            bias_flag_reg <= bias_flag_next;
            txp_flag_reg  <= txp_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // module monitor values
    ////////////////////////////////////////////////////////////////////////////

    reg  [MON_W-1:0] temp_mon_reg;
    reg  [MON_W-1:0] vcc_mon_reg;

    // sampled every cycle; the pair logic below keeps an msb then lsb read coherent
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            temp_mon_reg <= `TDFB_MON_RESET;
            vcc_mon_reg  <= `TDFB_MON_RESET;
        end else begin
            temp_mon_reg <= temperature_in;
            vcc_mon_reg  <= supply_voltage_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // monitor pairs: the low byte is frozen when its high byte is read
    ////////////////////////////////////////////////////////////////////////////

    wire       temp_hi_rd;
    wire       vcc_hi_rd;
    wire [7:0] temp_lo_byte;
    wire [7:0] vcc_lo_byte;
    reg        temp_pair_reg;
    reg        vcc_pair_reg;
    reg  [7:0] temp_lo_hold_reg;
    reg  [7:0] vcc_lo_hold_reg;

    // a host reading msb then lsb must not see a carry slip between the two reads
    assign temp_hi_rd = tdfb_hit(rd_strobe, rd_addr, `TDFB_TEMP_HI);
    assign vcc_hi_rd  = tdfb_hit(rd_strobe, rd_addr, `TDFB_VCC_HI);

    // any other read ends the pair, so a lone lsb read shows the live value
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            temp_pair_reg    <= 1'b0;
            vcc_pair_reg     <= 1'b0;
            temp_lo_hold_reg <= `TDFB_ZERO_BYTE;
            vcc_lo_hold_reg  <= `TDFB_ZERO_BYTE;
        end else begin
            if (rd_strobe) begin
                temp_pair_reg <= temp_hi_rd;
                vcc_pair_reg  <= vcc_hi_rd;
            end
            if (temp_hi_rd) begin
                temp_lo_hold_reg <= temp_mon_reg[7:0];
            end
            if (vcc_hi_rd) begin
                vcc_lo_hold_reg <= vcc_mon_reg[7:0];
            end
        end
    end

    // lsb of a pair comes from the sample its msb was taken from
    // limitation: the pair only holds while no other byte is read in between
    assign temp_lo_byte = temp_pair_reg ? temp_lo_hold_reg : temp_mon_reg[7:0];
    assign vcc_lo_byte  = vcc_pair_reg ? vcc_lo_hold_reg : vcc_mon_reg[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // read port toward the serial engine
    ////////////////////////////////////////////////////////////////////////////

    reg  [7:0] rd_mux;

    // reserved and unmapped bytes fall to zero; there is no write path at all
    // limitation: bytes past 33 belong to other blocks and also read zero here
    always @* begin
        case (rd_addr)
            `TDFB_CHANNEL_LOS: rd_mux = {4'h0, los_reg};
            `TDFB_TX_FAULT:    rd_mux = {4'h0, fault_reg};
            `TDFB_TEMP_FLAGS:  rd_mux = {temp_flag_reg, 4'h0};
            `TDFB_VCC_FLAGS:   rd_mux = {vcc_flag_reg, 4'h0};
            `TDFB_RXP_CH12:    rd_mux = rxp_flag_reg[15:8];
            `TDFB_RXP_CH34:    rd_mux = rxp_flag_reg[7:0];
            `TDFB_BIAS_CH12:   rd_mux = bias_flag_reg[15:8];
            `TDFB_BIAS_CH34:   rd_mux = bias_flag_reg[7:0];
            `TDFB_TXP_CH12:    rd_mux = txp_flag_reg[15:8];
            `TDFB_TXP_CH34:    rd_mux = txp_flag_reg[7:0];
            `TDFB_TEMP_HI:     rd_mux = temp_mon_reg[15:8];
            `TDFB_TEMP_LO:     rd_mux = temp_lo_byte;
            `TDFB_VCC_HI:      rd_mux = vcc_mon_reg[15:8];
            `TDFB_VCC_LO:      rd_mux = vcc_lo_byte;
            default:           rd_mux = `TDFB_ZERO_BYTE;
        endcase
    end

    // data is taken at the strobe edge, the same edge that clears the byte
    // rd_data then holds between reads, so a slow engine may fetch it late
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data  <= `TDFB_ZERO_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_strobe;
            if (rd_strobe) begin
                rd_data <= rd_mux;
            end
        end
    end

endmodule

// ===== rtl/tdfb_map.vh
// byte offsets, field positions and reset values of the diagnostic flag bank
`ifndef TDFB_MAP_VH
`define TDFB_MAP_VH

`define TDFB_ADDR_W           7
`define TDFB_CHANNEL_LOS      7'h03
`define TDFB_TX_FAULT         7'h04
`define TDFB_RSVD_A           7'h05
`define TDFB_TEMP_FLAGS       7'h06
`define TDFB_VCC_FLAGS        7'h07
`define TDFB_RSVD_B           7'h08
`define TDFB_RXP_CH12         7'h09
`define TDFB_RXP_CH34         7'h0A
`define TDFB_BIAS_CH12        7'h0B
`define TDFB_BIAS_CH34        7'h0C
`define TDFB_TXP_CH12         7'h0D
`define TDFB_TXP_CH34         7'h0E
`define TDFB_RSVD_SET4_LO     7'h0F
`define TDFB_RSVD_SET6_HI     7'h14
`define TDFB_RSVD_C           7'h15
`define TDFB_TEMP_HI          7'h16
`define TDFB_TEMP_LO          7'h17
`define TDFB_VCC_HI           7'h1A
`define TDFB_VCC_LO           7'h1B

// module flag nibble sits in bits 7..4, bits 3..0 reserved
`define TDFB_MOD_NIB_LSB      4
// nibble order from msb: high alarm, low alarm, high warning, low warning
`define TDFB_NIB_HA           3
`define TDFB_NIB_LA           2
`define TDFB_NIB_HW           1
`define TDFB_NIB_LW           0
// threshold word order inside a 64-bit threshold bus
`define TDFB_THR_HA_LSB       48
`define TDFB_THR_LA_LSB       32
`define TDFB_THR_HW_LSB       16
`define TDFB_THR_LW_LSB       0

`define TDFB_FLAG_RESET       8'h00
`define TDFB_ZERO_BYTE        8'h00
`define TDFB_MON_RESET        16'h0000

`endif

// ===== verification/tdfb_chk.sv
// concurrent checks on the read port of the diagnostic flag bank
`timescale 1ns/1ns
`include "tdfb_map.vh"
module tdfb_chk #(
    parameter MON_W = 16,
    parameter CH_N  = 4
) (
    input wire                    clock,
    input wire                    resetn,
    input wire                    module_reset_n,
    input wire                    rd_strobe,
    input wire [`TDFB_ADDR_W-1:0] rd_addr,
    input wire [7:0]              rd_data,
    input wire                    rd_valid,
    input wire [CH_N-1:0]         rx_los_in,
    input wire [CH_N-1:0]         tx_fault_in
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // reserved places in the flag and monitor area, plus everything unmapped
    wire rsvd_hit = rd_strobe && (rd_addr < `TDFB_CHANNEL_LOS || rd_addr == `TDFB_RSVD_A
        || rd_addr == `TDFB_RSVD_B || (rd_addr > `TDFB_TXP_CH34 && rd_addr < `TDFB_TEMP_HI)
        || rd_addr == 7'h18 || rd_addr == 7'h19 || rd_addr > `TDFB_VCC_LO);
    // pin high long enough that its synchroniser no longer holds flags clear
    reg  [2:0] pin_high_cnt;
    wire       pin_settled;
    // counts consecutive high samples of the pin, saturating at seven
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_high_cnt <= 3'h0;
        end else if (!module_reset_n) begin
            pin_high_cnt <= 3'h0;
        end else if (pin_high_cnt != 3'h7) begin
            pin_high_cnt <= pin_high_cnt + 3'h1;
        end
    end
    assign pin_settled = module_reset_n && (pin_high_cnt >= 3'h6);
    ////////////////////////////////////////////////////////////////////////////////
    a_answer_next_cycle: assert property (rd_strobe |=> rd_valid) else $error("no answer");
    a_no_stray_valid: assert property (!rd_strobe |=> !rd_valid) else $error("stray valid");
    a_rsvd_reads_zero: assert property (rsvd_hit |=> rd_data == 8'h00)
        else $error("reserved byte not zero");
    a_los_upper_zero: assert property (rd_strobe && rd_addr == `TDFB_CHANNEL_LOS
        |=> rd_data[7:4] == 4'h0) else $error("unsupported bits set");
    a_fault_upper_zero: assert property (rd_strobe && rd_addr == `TDFB_TX_FAULT
        |=> rd_data[7:4] == 4'h0) else $error("fault reserved bits set");
    a_module_low_zero: assert property (rd_strobe && (rd_addr == `TDFB_TEMP_FLAGS
        || rd_addr == `TDFB_VCC_FLAGS) |=> rd_data[3:0] == 4'h0) else $error("low nibble set");
    a_los_latched: assert property (rd_strobe && rd_addr == `TDFB_CHANNEL_LOS && pin_settled
        && $past(rx_los_in[0]) && $past(resetn) |=> rd_data[0]) else $error("los flag lost");
    a_fault_latched: assert property (rd_strobe && rd_addr == `TDFB_TX_FAULT && pin_settled
        && $past(tx_fault_in[3]) && $past(resetn) |=> rd_data[3]) else $error("fault flag lost");
    a_pin_clears_flags: assert property (rd_strobe && rd_addr == `TDFB_CHANNEL_LOS
        && !module_reset_n && !$past(module_reset_n, 6) |=> rd_data == 8'h00)
        else $error("flags kept under pin reset");
    a_data_holds: assert property (!rd_strobe |=> $stable(rd_data)) else $error("data moved");
    c_los_read: cover property (rd_strobe && rd_addr == `TDFB_CHANNEL_LOS ##1 rd_data != 8'h00);
    c_pin_reset_read: cover property (!module_reset_n && rd_strobe);
    c_monitor_read: cover property (rd_strobe && rd_addr == `TDFB_TEMP_HI);
endmodule
bind tdfb_flag_bank tdfb_chk #(.MON_W(MON_W), .CH_N(CH_N)) u_chk (.clock, .resetn,
    .module_reset_n, .rd_strobe, .rd_addr, .rd_data, .rd_valid, .rx_los_in, .tx_fault_in);

// ===== verification/tdfb_host.sv
// host side reader standing in for the serial management engine
`timescale 1ns/1ns
module tdfb_host (
    input  wire       clock,
    output reg        rd_strobe,
    output reg  [6:0] rd_addr,
    input  wire [7:0] rd_data,
    input  wire       rd_valid
);
    // idle: no request, address parked
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 7'h7F;
    end
    // one byte per call; the address is inverted when idle so a stale value never looks valid
    task read(input [6:0] a, output [7:0] d, output ok);
        begin
            @(posedge clock);
            #1 rd_strobe = 1'b1;
            rd_addr = a;
            @(posedge clock);
            #1 rd_strobe = 1'b0;
            rd_addr = ~a;
            ok = rd_valid;
            d = rd_data;
        end
    endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the diagnostic flag bank
`timescale 1ns/1ns
module tb_top;
    localparam [63:0] NORM  = 64'h5000_5000_5000_5000;
    localparam [63:0] U_THR = 64'h9000_1000_8000_2000;
    localparam [63:0] T_THR = 64'h0050_FFEC_0046_FFF6;
    localparam [63:0] T_ADR = 64'h0607_090A_0B0C_0D0E;
    localparam [63:0] T_EXP = 64'h50A0_A005_0A00_0050;
    reg         clock = 1'b0;
    reg         resetn = 1'b0;
    reg         module_reset_n = 1'b1;
    reg  [3:0]  rx_los_in = 4'h0;
    reg  [3:0]  tx_fault_in = 4'h0;
    reg  [15:0] temperature_in = 16'h0031;
    reg  [15:0] supply_voltage_in = 16'h5A3C;
    reg  [63:0] rx_power_in = NORM;
    reg  [63:0] tx_bias_in = NORM;
    reg  [63:0] tx_power_in = NORM;
    wire        rd_strobe;
    wire [6:0]  rd_addr;
    wire [7:0]  rd_data;
    wire        rd_valid;
    integer     error_cnt = 0;
    integer     check_count = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    always #4 clock = ~clock;
    tdfb_flag_bank dut (.clock(clock), .resetn(resetn), .module_reset_n(module_reset_n),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .rx_los_in(rx_los_in), .tx_fault_in(tx_fault_in), .temperature_in(temperature_in),
        .supply_voltage_in(supply_voltage_in), .rx_power_in(rx_power_in),
        .tx_bias_in(tx_bias_in), .tx_power_in(tx_power_in), .temp_thresh(T_THR),
        .vcc_thresh(U_THR), .rx_power_thresh(U_THR), .tx_bias_thresh(U_THR),
        .tx_power_thresh(U_THR));
    tdfb_host host (.clock(clock), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
                error_cnt = error_cnt + 1;
            end
        end
    endtask
    // one read, answer must come with valid set
    task rd_chk(input [6:0] a, input [7:0] exp);
        reg [7:0] d;
        reg       ok;
        begin
            host.read(a, d, ok);
            check({7'h00, ok}, 8'h01);
            check(d, exp);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // whole map after reset: flags clear, reserved zero, monitors msb first
    task t_reset_map;
        integer a;
        reg [7:0] e;
        begin
            for (a = 0; a < 36; a = a + 1) begin
                e = a == 23 ? 8'h31 : a == 26 ? 8'h5A : a == 27 ? 8'h3C : 8'h00;
                rd_chk(a[6:0], e);
            end
        end
    endtask
    // latch, read-clear per byte, and a condition still present while read
    task t_los_fault;
        begin
            @(posedge clock);
            #1 rx_los_in = 4'h5;
            tx_fault_in = 4'hA;
            @(posedge clock);
            #1 rx_los_in = 4'h0;
            tx_fault_in = 4'h0;
            rd_chk(7'h04, 8'h0A);
            rd_chk(7'h03, 8'h05);
            rd_chk(7'h03, 8'h00);
            rd_chk(7'h04, 8'h00);
            rx_los_in = 4'h9;
            tx_fault_in = 4'h8;
            rd_chk(7'h03, 8'h09);
            rd_chk(7'h04, 8'h08);
            rx_los_in = 4'h0;
            tx_fault_in = 4'h0;
            rd_chk(7'h03, 8'h09);
            rd_chk(7'h03, 8'h00);
        end
    endtask
    // signed temperature low, others high or low on chosen channels
    task t_thresholds;
        integer i;
        begin
            @(posedge clock);
            #1 temperature_in = 16'hFFE2;
            supply_voltage_in = 16'hA000;
            rx_power_in = 64'h0800_5000_5000_A000;
            tx_bias_in = 64'h5000_5000_A000_5000;
            tx_power_in = 64'h5000_0800_5000_5000;
            repeat (2) @(posedge clock);
            rd_chk(7'h16, 8'hFF);
            rd_chk(7'h17, 8'hE2);
            temperature_in = 16'h0031;
            supply_voltage_in = 16'h5A3C;
            rx_power_in = NORM;
            tx_bias_in = NORM;
            tx_power_in = NORM;
            for (i = 0; i < 16; i = i + 1)
                rd_chk(T_ADR[62-8*(i%8) -: 7], i < 8 ? T_EXP[63-8*i -: 8] : 8'h00);
        end
    endtask
    // module reset pin clears a latched flag while low
    task t_pin_reset;
        begin
            rx_los_in = 4'h3;
            @(posedge clock);
            #1 rx_los_in = 4'h0;
            module_reset_n = 1'b0;
            repeat (12) @(posedge clock);
            rd_chk(7'h03, 8'h00);
            module_reset_n = 1'b1;
            repeat (8) @(posedge clock);
            rd_chk(7'h03, 8'h00);
            rx_los_in = 4'h2;
            rd_chk(7'h03, 8'h02);
            rx_los_in = 4'h0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        #1 resetn = 1'b1;
        t_reset_map;
        t_los_fault;
        t_thresholds;
        t_pin_reset;
        stop_test;
    end
    // hang guard
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        stop_test;
    end
endmodule
